// ---- design/cpu_sideband_control.sv ----
// Purpose: CPU-side sideband, snoop handshake and SMM pin logic.
// Assumes: Pins from outside pass two flip-flops; straps caught after reset.
// Notes:   Every output is registered.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1 - Processor floats its address bus the clock after address hold rises.
// R2 - Address hold is raised only after a pending writeback has finished.
// R3 - Address hold with modified hit inactive acts as backoff.
// R4 - In the newer mode burst last marks the final burst ready.
// R5 - Local device claim must arrive by end of first T2.
// R6 - Strap picks shared input as address bit 25 or local ready.
// R7 - Local ready input, when selected, marks the current cycle finished.
// R8 - With address bit 25 selected, local devices drive processor ready directly.
// R9 - Coprocessor drives floating point error on unmasked exceptions.
// R10 - Newer mode: shared output tells processor to ignore numeric errors.
// R11 - Older mode: shared output signals coprocessor still busy.
// R12 - Older mode: coprocessor drives busy input while operation incomplete.
// R13 - Older mode: a dedicated output resets the coprocessor.
// R14 - No L2 and config bit clear: shared output is processor backoff.
// R15 - Config bit set: shared output is local bus clock, 1X or 2X; code holds it high when the 2X strap is clear.
// R16 - Stop clock output asks processor to change frequency.
// R17 - System management interrupt requests SMM; optionally bidirectional.
// R18 - Config bit picks SMM active or SMM address strobe input.
// R19 - Config bit clear: shared output flushes processor cache on SMM entry.
// R20 - Config bit set: shared output answers each SMM address strobe.
// R21 - Modified hit input enabled by config; master waits for writeback.
// R22 - External address strobe driven when external master address valid.
// R23 - Processor acknowledges hold before chipset takes the bus.
// R24 - Direct ready drivers stay off while device claim is inactive.
// R25 - Strap functions are sampled at reset and held until next reset.
module cpu_sideband_control
    import sideband_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic strap_mode_late,
    input  wire logic strap_pin_addr25,
    input  wire logic strap_no_l2,
    input  wire logic strap_clk_2x,
    input  wire logic cfg_lclk_sel,
    input  wire logic cfg_smi_bidir,
    input  wire logic cfg_smm_strobe_sel,
    input  wire logic cfg_smm_ready_sel,
    input  wire logic cfg_modified_hit_n_en,
    input  wire logic writeback_pending,
    input  wire logic master_addr_valid,
    input  wire logic master_snoop_req,
    input  wire logic smi_request,
    input  wire logic clk_change_req,
    input  wire logic copro_reset_req,
    input  wire logic burst_last_n,
    input  wire logic copro_busy_in_n,
    input  wire logic shared_addr_pin,
    input  wire logic local_dev_claim_n,
    input  wire logic fp_error_n,
    input  wire logic smm_status_in_n,
    input  wire logic modified_hit_n,
    input  wire logic sys_mgmt_irq_in_n,
    input  wire logic bus_hold_ack,
    output logic      addr_hold_req,
    output logic      ext_addr_strobe_n,
    output logic      backoff_lclk_out,
    output logic      ignore_busy_out_n,
    output logic      copro_reset_n,
    output logic      stop_clock_req_n,
    output logic      sys_mgmt_irq_n,
    output logic      sys_mgmt_irq_oe_n,
    output logic      flush_ready_out_n,
    output logic      smm_in_progress,
    output logic      smi_seen_by_cpu,
    output logic      cpu_addr_bit25,
    output logic      local_ready_in_n,
    output logic      local_dev_seen,
    output logic      burst_final,
    output logic      fp_error_seen,
    output logic      hold_granted
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] raw_w;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    assign raw_w = {burst_last_n, copro_busy_in_n, shared_addr_pin, local_dev_claim_n,
                    fp_error_n, smm_status_in_n, modified_hit_n, sys_mgmt_irq_in_n,
                    bus_hold_ack};
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= {NSYNC{1'b1}};
            s2_q <= {NSYNC{1'b1}};
        end else begin
            s1_q <= raw_w;
            s2_q <= s1_q;
        end
    end
    logic burst_last_n_s_n;
    logic busy_s_n;
    logic shpin_s;
    logic ldev_s_n;
    logic fp_error_n_s_n;
    logic smms_s_n;
    logic modified_hit_n_s_n;
    logic smi_s_n;
    logic bus_hold_ack_s;
    assign {burst_last_n_s_n, busy_s_n, shpin_s, ldev_s_n, fp_error_n_s_n, smms_s_n, modified_hit_n_s_n, smi_s_n,
            bus_hold_ack_s} = s2_q;

    // ****************************************
    // Strap capture
    // ****************************************
    logic strap_done_q;
    logic mode_late_q;
    logic pin_a25_q;
    logic no_l2_q;
    logic clk2x_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_done_q <= 1'b0;
            mode_late_q  <= 1'b0;
            pin_a25_q    <= 1'b0;
            no_l2_q      <= 1'b0;
            clk2x_q      <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;              // see R25
            mode_late_q  <= strap_mode_late;
            pin_a25_q    <= strap_pin_addr25;  // see R6
            no_l2_q      <= strap_no_l2;
            clk2x_q      <= strap_clk_2x;
        end
    end

    // ****************************************
    // Snoop and address hold sequencer
    // ****************************************
    snoop_state_t st_q, st_d;
    logic modified_hit_n_act_w;
    assign modified_hit_n_act_w = cfg_modified_hit_n_en && !modified_hit_n_s_n;   // see R21
    always_comb begin
        st_d = st_q;
        case (st_q)
            SNP_IDLE: if (master_snoop_req) st_d = SNP_WAIT;
            SNP_WAIT: if (!writeback_pending) st_d = SNP_HOLD;   // see R2
            SNP_HOLD: if (!master_snoop_req && !modified_hit_n_act_w) st_d = SNP_IDLE;
            default:  st_d = SNP_IDLE;
        endcase
    end
    logic addr_hold_req_d;
    logic backoff_d;
    logic lclk_q;
    assign addr_hold_req_d   = (st_d == SNP_HOLD);
    assign backoff_d = !(addr_hold_req_d && !modified_hit_n_act_w);   // see R3 R14
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q              <= SNP_IDLE;
            addr_hold_req     <= 1'b0;
            ext_addr_strobe_n <= 1'b1;
            lclk_q            <= 1'b0;
        end else begin
            st_q              <= st_d;
            addr_hold_req     <= addr_hold_req_d;                         // see R1
            ext_addr_strobe_n <= !(addr_hold_req_d && master_addr_valid); // see R22
            lclk_q            <= !lclk_q;
        end
    end

    // ****************************************
    // Shared pin outputs
    // ****************************************
    logic lclk_d;
    logic bo_lclk_d;
    logic ign_busy_d;
    logic cprst_d;
    logic smm_in_d;
    logic flush_rdy_d;
    logic a25_d;
    logic lrdy_d;
    logic ldev_d;
    logic final_d;
    logic fp_error_n_d;
    assign lclk_d      = clk2x_q ? lclk_q : 1'b1;  // see R15
    assign bo_lclk_d   = (cfg_lclk_sel && no_l2_q) ? lclk_d : backoff_d;   // see R14 R15
    assign ign_busy_d  = mode_late_q ? fp_error_n_s_n : busy_s_n;   // see R10 R11 R12
    assign cprst_d     = mode_late_q ? 1'b1 : !copro_reset_req;   // see R13
    assign smm_in_d    = !smms_s_n;   // see R18
    assign flush_rdy_d = cfg_smm_ready_sel ? !(cfg_smm_strobe_sel && !smms_s_n)   // see R20
                                           : !(smm_in_d && !smm_in_progress);     // see R19
    assign a25_d       = pin_a25_q ? shpin_s : 1'b0;   // see R6
    assign lrdy_d      = pin_a25_q ? 1'b1 : shpin_s;   // see R7
    assign ldev_d      = !ldev_s_n;   // see R5
    assign final_d     = mode_late_q && !burst_last_n_s_n;   // see R4
    assign fp_error_n_d      = !fp_error_n_s_n;   // see R9
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            backoff_lclk_out  <= 1'b1;
            ignore_busy_out_n <= 1'b1;
            copro_reset_n     <= 1'b0;
            stop_clock_req_n  <= 1'b1;
            sys_mgmt_irq_n    <= 1'b1;
            sys_mgmt_irq_oe_n <= 1'b0;
            flush_ready_out_n <= 1'b1;
            smm_in_progress   <= 1'b0;
            smi_seen_by_cpu   <= 1'b0;
            cpu_addr_bit25    <= 1'b0;
            local_ready_in_n  <= 1'b1;
            local_dev_seen    <= 1'b0;
            burst_final       <= 1'b0;
            fp_error_seen     <= 1'b0;
            hold_granted      <= 1'b0;
        end else begin
            backoff_lclk_out  <= bo_lclk_d;
            ignore_busy_out_n <= ign_busy_d;
            copro_reset_n     <= cprst_d;
            stop_clock_req_n  <= !clk_change_req;                   // see R16
            sys_mgmt_irq_n    <= !smi_request;                      // see R17
            sys_mgmt_irq_oe_n <= cfg_smi_bidir && !smi_request;     // see R17
            flush_ready_out_n <= flush_rdy_d;
            smm_in_progress   <= smm_in_d;
            smi_seen_by_cpu   <= cfg_smi_bidir && !smi_s_n;
            cpu_addr_bit25    <= a25_d;
            local_ready_in_n  <= lrdy_d;
            local_dev_seen    <= ldev_d;
            burst_final       <= final_d;
            fp_error_seen     <= fp_error_n_d;
            hold_granted      <= bus_hold_ack_s;                            // see R23
        end
    end
endmodule
`default_nettype wire

// ---- design/sideband_pkg.sv ----
// Purpose: Constants shared by the CPU sideband control block.
// Assumes: One 100 MHz clock.
// Notes:   Strap and configuration bits arrive as plain ports.
package sideband_pkg;
    // ****************************************
    // Mode encodings
    // ****************************************
    localparam logic STRAP_MODE_LATE   = 1'b1;   // Newer processor family.
    localparam logic STRAP_PIN_ADDR25  = 1'b1;   // Shared input is address bit 25.
    localparam logic STRAP_CLK_2X      = 1'b1;   // Processor takes a 2X clock.
    // ****************************************
    // Timing counts
    // ****************************************
    localparam int   CLK_PERIOD_NS     = 10;
    localparam int   COPRO_RST_NS      = 100;
    localparam logic [3:0] COPRO_RST_CYC = 4'(COPRO_RST_NS / CLK_PERIOD_NS);
    localparam logic [3:0] RST_VAL_CNT = 4'h0;
    // ****************************************
    // Control sequencer states
    // ****************************************
    typedef enum logic [2:0] {
        SNP_IDLE = 3'b001,
        SNP_WAIT = 3'b010,
        SNP_HOLD = 3'b100
    } snoop_state_t;
endpackage

// ---- sim/cpu_sideband_control_bench.sv ----
// Purpose: Self-checking bench for the CPU sideband block.
// Assumes: 100 MHz clock; pins pass a two-flop sync.
// Notes:   A second reset runs the older processor mode.
`timescale 1ns/1ps
`default_nettype none
module cpu_sideband_control_bench;
    import sideband_pkg::*;
    logic mclk = 1'h0, rstn = 1'h0, strap_mode_late = 1'h1, strap_pin_addr25 = 1'h1;
    logic strap_clk_2x = 1'h1, cfg_lclk_sel = 1'h0, cfg_modified_hit_n_en = 1'h0, want_hit = 1'h0;
    logic cfg_smm_strobe_sel = 1'h0, cfg_smm_ready_sel = 1'h0, writeback_pending = 1'h0;
    logic master_snoop_req = 1'h0, smi_request = 1'h0, cfg_smi_bidir = 1'h0;
    logic local_dev_claim_n = 1'h1, burst_last_n = 1'h1, sys_mgmt_irq_in_n = 1'h1;
    logic clk_change_req = 1'h0, copro_reset_req = 1'h0, shared_addr_pin = 1'h0;
    logic want_err = 1'h0, want_busy = 1'h0;
    wire logic strap_no_l2 = 1'h1, master_addr_valid;
    wire logic copro_busy_in_n, fp_error_n, smm_status_in_n, modified_hit_n, bus_hold_ack;
    wire logic addr_hold_req, ext_addr_strobe_n, backoff_lclk_out, ignore_busy_out_n;
    wire logic copro_reset_n, stop_clock_req_n, sys_mgmt_irq_n, sys_mgmt_irq_oe_n;
    wire logic flush_ready_out_n, smm_in_progress, smi_seen_by_cpu, cpu_addr_bit25;
    wire logic local_ready_in_n, local_dev_seen, burst_final, fp_error_seen, hold_granted;
    int err_total = 0, samples_checked = 0;
    always #5 mclk = ~mclk;
    cpu_sideband_control u_cpu_sideband_control (.*);
    host_cpu_model u_host_cpu_model (.*);
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic do_reset(input logic late);
        @(posedge mclk) rstn <= 1'h0;
        strap_mode_late <= late;
        strap_clk_2x <= late;
        strap_pin_addr25 <= late;
        tick(4);
        chk(copro_reset_n, 1'h0);
        @(posedge mclk) rstn <= 1'h1;
        tick(3);
    endtask
    task automatic t_snoop;
        @(posedge mclk) writeback_pending <= 1'h1;
        master_snoop_req <= 1'h1;
        tick(5);
        chk(addr_hold_req, 1'h0);
        @(posedge mclk) writeback_pending <= 1'h0;
        tick(8);
        chk(addr_hold_req, 1'h1);
        chk(backoff_lclk_out, 1'h0);
        chk(ext_addr_strobe_n, 1'h0);
        chk(hold_granted, 1'h1);
        @(posedge mclk) cfg_modified_hit_n_en <= 1'h1;
        want_hit <= 1'h1;
        tick(4);
        chk(backoff_lclk_out, 1'h1);
        @(posedge mclk) master_snoop_req <= 1'h0;
        tick(6);
        chk(addr_hold_req, 1'h1);
        chk(backoff_lclk_out, 1'h1);
        @(posedge mclk) want_hit <= 1'h0;
        tick(6);
        chk(addr_hold_req, 1'h0);
        cfg_modified_hit_n_en <= 1'h0;
        @(posedge mclk) master_snoop_req <= 1'h1;
        tick(3);
        chk(addr_hold_req, 1'h1);
        @(posedge mclk) master_snoop_req <= 1'h0;
        tick(2);
        chk(addr_hold_req, 1'h0);
        $display("snoop test done");
    endtask
    task automatic t_side;
        @(posedge mclk) clk_change_req <= 1'h1;
        smi_request <= 1'h1;
        tick(2);
        chk(stop_clock_req_n, 1'h0);
        chk(sys_mgmt_irq_n, 1'h0);
        tick(3);
        chk(flush_ready_out_n, 1'h0);
        chk(smm_in_progress, 1'h1);
        tick(1);
        chk(flush_ready_out_n, 1'h1);
        tick(2);
        @(posedge mclk) clk_change_req <= 1'h0;
        smi_request <= 1'h0;
        cfg_smm_strobe_sel <= 1'h1;
        cfg_smm_ready_sel <= 1'h1;
        tick(2);
        chk(flush_ready_out_n, 1'h0);
        tick(6);
        chk(smm_in_progress, 1'h0);
        chk(flush_ready_out_n, 1'h1);
        cfg_smm_strobe_sel <= 1'h0;
        cfg_smm_ready_sel <= 1'h0;
        @(posedge mclk) cfg_smi_bidir <= 1'h1;
        sys_mgmt_irq_in_n <= 1'h0;
        tick(4);
        chk(sys_mgmt_irq_oe_n, 1'h1);
        chk(smi_seen_by_cpu, 1'h1);
        @(posedge mclk) cfg_smi_bidir <= 1'h0;
        sys_mgmt_irq_in_n <= 1'h1;
        $display("side test done");
    endtask
    task automatic t_pins(input logic late);
        @(posedge mclk) shared_addr_pin <= late;
        want_err <= 1'h1;
        want_busy <= 1'h1;
        copro_reset_req <= 1'h1;
        local_dev_claim_n <= 1'h0;
        burst_last_n <= 1'h0;
        tick(5);
        chk(late ? cpu_addr_bit25 : local_ready_in_n, late);
        chk(fp_error_seen, 1'h1);
        chk(ignore_busy_out_n, 1'h0);
        chk(copro_reset_n, late);
        chk(local_dev_seen, 1'h1);
        chk(burst_final, late);
        @(posedge mclk) want_err <= 1'h0;
        want_busy <= 1'h0;
        copro_reset_req <= 1'h0;
        local_dev_claim_n <= 1'h1;
        burst_last_n <= 1'h1;
        $display("pin test done");
    endtask
    task automatic t_lclk(input logic late);
        logic prev;
        @(posedge mclk) cfg_lclk_sel <= 1'h1;
        tick(4);
        prev = backoff_lclk_out;
        tick(1);
        chk(backoff_lclk_out, late ? !prev : 1'h1);
        @(posedge mclk) cfg_lclk_sel <= 1'h0;
        $display("clock test done");
    endtask
    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        stop_test;
    end
    initial begin
        do_reset(1'h1);
        t_snoop;
        t_side;
        t_pins(1'h1);
        t_lclk(1'h1);
        do_reset(1'h0);
        t_pins(1'h0);
        t_lclk(1'h0);
        stop_test;
    end
endmodule
`default_nettype wire

// ---- sim/cpu_sideband_control_sva.sv ----
// Purpose: Timing checks on the CPU sideband block ports.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module sideband_checker (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic writeback_pending,
    input wire logic master_snoop_req,
    input wire logic addr_hold_req,
    input wire logic cfg_lclk_sel,
    input wire logic cfg_modified_hit_n_en,
    input wire logic strap_no_l2,
    input wire logic backoff_lclk_out,
    input wire logic ext_addr_strobe_n,
    input wire logic clk_change_req,
    input wire logic stop_clock_req_n,
    input wire logic smi_request,
    input wire logic sys_mgmt_irq_n,
    input wire logic strap_mode_late,
    input wire logic copro_reset_req,
    input wire logic copro_reset_n,
    input wire logic strap_pin_addr25,
    input wire logic shared_addr_pin,
    input wire logic cpu_addr_bit25
);
    logic [1:0] up_q;
    wire        up = (up_q == 2'h3);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) up_q <= 2'h0;
        else if (!up) up_q <= up_q + 2'h1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    hold_wb_a: assert property ($rose(addr_hold_req) |-> !$past(writeback_pending))
        else $error("hold raised with writeback pending");
    hold_rise_a: assert property ($rose(master_snoop_req) && !writeback_pending ##1
        master_snoop_req && !writeback_pending |-> ##1 addr_hold_req)
        else $error("hold late after snoop request");
    hold_stand_a: assert property (addr_hold_req && master_snoop_req |=> addr_hold_req)
        else $error("hold dropped during snoop");
    backoff_a: assert property (up && strap_no_l2 && !cfg_lclk_sel && !$past(cfg_lclk_sel)
        && !cfg_modified_hit_n_en && !$past(cfg_modified_hit_n_en) |-> backoff_lclk_out == !addr_hold_req)
        else $error("backoff not tied to hold");
    strobe_a: assert property (!ext_addr_strobe_n |-> addr_hold_req)
        else $error("strobe without hold");
    stop_clk_a: assert property (up |-> stop_clock_req_n == !$past(clk_change_req))
        else $error("stop clock mismatch");
    smi_out_a: assert property (up |-> sys_mgmt_irq_n == !$past(smi_request))
        else $error("smi mismatch");
    copro_rst_a: assert property (up && !strap_mode_late
        |-> copro_reset_n == !$past(copro_reset_req))
        else $error("coprocessor reset mismatch");
    addr25_a: assert property (up && strap_pin_addr25
        |-> cpu_addr_bit25 == $past(shared_addr_pin, 3))
        else $error("address bit 25 mismatch");
endmodule
bind cpu_sideband_control sideband_checker u_sideband_checker (.*);
`default_nettype wire

// ---- sim/host_cpu_model.sv ----
// Purpose: Processor and coprocessor pins facing the sideband block.
// Assumes: Answers one clock after each request.
// Notes:   Bench flags choose hit, error and busy.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic addr_hold_req,
    input  wire logic sys_mgmt_irq_n,
    input  wire logic want_hit,
    input  wire logic want_err,
    input  wire logic want_busy,
    output var logic  bus_hold_ack,
    output var logic  smm_status_in_n,
    output var logic  modified_hit_n,
    output var logic  master_addr_valid,
    output wire logic fp_error_n,
    output wire logic copro_busy_in_n
);
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus_hold_ack    <= 1'h0;
            smm_status_in_n <= 1'h1;
            modified_hit_n  <= 1'h1;
            master_addr_valid <= 1'h0;
        end else begin
            master_addr_valid <= addr_hold_req;
            bus_hold_ack    <= addr_hold_req;
            smm_status_in_n <= sys_mgmt_irq_n;
            modified_hit_n  <= !(want_hit && addr_hold_req);
        end
    end
    assign fp_error_n      = !want_err;
    assign copro_busy_in_n = !want_busy;
endmodule
`default_nettype wire
